// *** verilog/line_status_pkg.sv ***
// Package for the per-channel line status and event flag block.
// Assumes eight channels on an 8-bit control port address space.
package line_status_pkg;
   localparam int NUM_CH = 8;
   // Per-channel spacing; low five address bits select the register
   localparam logic [7:0] CH_STRIDE = 8'h20;
   localparam logic [4:0] OFS_LINE_STATUS_A = 5'h14;
   localparam logic [4:0] OFS_LINE_STATUS_B = 5'h15;
   localparam logic [4:0] OFS_EVENT_FLAGS_A = 5'h16;
   localparam logic [4:0] OFS_EVENT_FLAGS_B = 5'h17;
   localparam logic [4:0] OFS_ERROR_COUNT_LOW = 5'h18;
   localparam logic [4:0] OFS_ERROR_COUNT_HIGH = 5'h19;
   // Field positions
   localparam int BIT_SIGNAL_LOSS = 0;
   localparam int BIT_TX_CLOCK_LOSS = 3;
   localparam int BIT_REMOTE_LOOP = 5;
   // Reset values
   localparam logic [7:0] RESET_FLAGS = 8'h00;
   localparam logic [7:0] RESET_RD_DATA = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   // Transmit clock must toggle within this many master clock cycles
   localparam int TX_LOSS_CYCLES = 70;
   localparam logic [6:0] TX_LOSS_LIMIT = 7'(TX_LOSS_CYCLES);
   localparam logic [6:0] TX_CNT_MAX = 7'h7F;
endpackage

// *** verilog/line_status_interrupt_flags.sv ***
// Line status, sticky event flags and error counter readout, 8 channels.
// Assumes detectors run on sys_clk_i; the transmit clocks are async pins.
// Notes on behaviour
// - Status bit 0 reads live signal loss state, with no reset value of its own.
// - Edge select 0: signal loss event only on a rising status change.
// - Edge select 1: signal loss event on every status change.
// - Second status register bit 5 shows remote loop state, others zero.
// - All registers repeat per channel at a 0x20 stride from 0x14.
// - Reading the first flag register clears all its bits except those set again on the same edge.
// - Reading the second flag register clears it; irq_o drops only when no other unmasked flag remains.
// - First flags hold loop codes, sync, clock loss, driver, alarm, loss.
// - Second flags hold amplitude, jitter, error, zeros, cv, timer, counter.
// - Counter low byte register shows error count bits 7..0.
// - Transmit clock loss set after more than 70 cycles without a toggle.
// - Counter high byte register at the next address shows bits 15..8.
`timescale 1ns/10ps
module line_status_interrupt_flags
   import line_status_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Control port
   input wire logic rd_strobe_i,
   input wire logic [7:0] addr_i,
   output logic [7:0] rd_data_o,
   output logic irq_o,
   // Per-channel detector levels (bits 6,5,4,2,1 of the first status)
   input wire logic [NUM_CH-1:0] signal_loss_state_i,
   input wire logic [NUM_CH-1:0][7:0] line_alarm_i,
   input wire logic [NUM_CH-1:0] remote_loop_state_i,
   input wire logic [NUM_CH-1:0] tx_clock_in_i,
   // Per-channel mask and edge select for the first flag register
   input wire logic [NUM_CH-1:0][7:0] event_mask_a_i,
   input wire logic [NUM_CH-1:0][7:0] edge_select_a_i,
   // Per-channel event pulses and mask for the second flag register
   input wire logic [NUM_CH-1:0][7:0] event_pulse_b_i,
   input wire logic [NUM_CH-1:0][7:0] event_mask_b_i,
   // Per-channel error counters
   input wire logic [NUM_CH-1:0][15:0] error_count_i
);

   logic [7:0] status_a [NUM_CH];
   logic [7:0] prev_a [NUM_CH];
   logic [7:0] next_prev_a [NUM_CH];
   logic [7:0] flags_a [NUM_CH];
   logic [7:0] next_flags_a [NUM_CH];
   logic [7:0] flags_b [NUM_CH];
   logic [7:0] next_flags_b [NUM_CH];
   logic [7:0] set_a [NUM_CH];
   logic [NUM_CH-1:0] tx_sync1;
   logic [NUM_CH-1:0] tx_sync2;
   logic [NUM_CH-1:0] tx_prev;
   logic [NUM_CH-1:0] tx_loss;
   logic [NUM_CH-1:0] next_tx_loss;
   logic [6:0] tx_cnt [NUM_CH];
   logic [6:0] next_tx_cnt [NUM_CH];
   logic [NUM_CH-1:0] clr_a;
   logic [NUM_CH-1:0] clr_b;
   logic [2:0] sel_ch;
   logic [4:0] sel_ofs;
   logic [7:0] next_rd_data;
   logic next_irq;
   logic flag_seen;

   // Address split: channel in the top bits, register in the low bits
   assign sel_ch = addr_i[7:5];
   assign sel_ofs = addr_i[4:0];

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_ch
         // Live status assembly
         assign status_a[c] = {1'b0, line_alarm_i[c][6:4], tx_loss[c],
            line_alarm_i[c][2:1], signal_loss_state_i[c]};

         // Clearing reads addressed to this channel
         assign clr_a[c] = rd_strobe_i && (sel_ch == 3'(c))
            && (sel_ofs == OFS_EVENT_FLAGS_A);
         assign clr_b[c] = rd_strobe_i && (sel_ch == 3'(c))
            && (sel_ofs == OFS_EVENT_FLAGS_B);

         // Event per bit: rising edge, or any change where selected
         assign set_a[c] =
            ((status_a[c] ^ prev_a[c]) & edge_select_a_i[c])
            | (status_a[c] & ~prev_a[c] & ~edge_select_a_i[c]);

         // Next flags, idle-time counter and history
         always_comb begin
            next_prev_a[c] = status_a[c];
            // Set beats a same-cycle clearing read
            next_flags_a[c] = (flags_a[c] & ~{8{clr_a[c]}})
               | set_a[c];
            next_flags_b[c] = (flags_b[c] & ~{8{clr_b[c]}})
               | event_pulse_b_i[c];
            if (tx_sync2[c] != tx_prev[c]) begin
               next_tx_cnt[c] = 7'h00;
            end else if (tx_cnt[c] != TX_CNT_MAX) begin
               next_tx_cnt[c] = tx_cnt[c] + 7'h01;
            end else begin
               next_tx_cnt[c] = tx_cnt[c];
            end
            next_tx_loss[c] = (next_tx_cnt[c] > TX_LOSS_LIMIT);
         end

         // Registers of the channel
         always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               prev_a[c] <= RESET_FLAGS;
               flags_a[c] <= RESET_FLAGS;
               flags_b[c] <= RESET_FLAGS;
               tx_sync1[c] <= 1'b0;
               tx_sync2[c] <= 1'b0;
               tx_prev[c] <= 1'b0;
               tx_cnt[c] <= 7'h00;
               tx_loss[c] <= 1'b0;
            end else begin
               prev_a[c] <= next_prev_a[c];
               flags_a[c] <= next_flags_a[c];
               flags_b[c] <= next_flags_b[c];
               tx_sync1[c] <= tx_clock_in_i[c];
               tx_sync2[c] <= tx_sync1[c];
               tx_prev[c] <= tx_sync2[c];
               tx_cnt[c] <= next_tx_cnt[c];
               tx_loss[c] <= next_tx_loss[c];
            end
         end

         // Rising loss with edge select 0 latches the flag next cycle
         a_loss_rise: assert property (@(posedge sys_clk_i)
            disable iff (sys_rst_i)
            (!edge_select_a_i[c][BIT_SIGNAL_LOSS]
             && $rose(signal_loss_state_i[c]))
            |-> ##1 flags_a[c][BIT_SIGNAL_LOSS])
            else $error("signal loss rise not latched");

         // Falling loss with edge select 0 and no prior flag stays clear
         a_loss_no_fall: assert property (@(posedge sys_clk_i)
            disable iff (sys_rst_i)
            (!edge_select_a_i[c][BIT_SIGNAL_LOSS]
             && $fell(signal_loss_state_i[c])
             && !flags_a[c][BIT_SIGNAL_LOSS])
            |-> ##1 !flags_a[c][BIT_SIGNAL_LOSS])
            else $error("signal loss fall latched without edge select");

         // Any change with edge select 1 latches the flag
         a_loss_any: assert property (@(posedge sys_clk_i)
            disable iff (sys_rst_i)
            (edge_select_a_i[c][BIT_SIGNAL_LOSS]
             && $changed(signal_loss_state_i[c]))
            |-> ##1 flags_a[c][BIT_SIGNAL_LOSS])
            else $error("signal loss change not latched");

         // Clearing read with no new event empties the first flags
         a_clear_read: assert property (@(posedge sys_clk_i)
            disable iff (sys_rst_i)
            (clr_a[c] && (set_a[c] == 8'h00))
            |-> ##1 (flags_a[c] == 8'h00))
            else $error("first flags not cleared by read");

         // Pulse on a clearing read of the second flags survives
         a_set_wins: assert property (@(posedge sys_clk_i)
            disable iff (sys_rst_i)
            (clr_b[c] && event_pulse_b_i[c][0])
            |-> ##1 flags_b[c][0])
            else $error("event lost on clearing read");

         // Set flag holds while no read clears it
         a_flag_hold: assert property (@(posedge sys_clk_i)
            disable iff (sys_rst_i)
            (flags_b[c][7] && !clr_b[c]) |-> ##1 flags_b[c][7])
            else $error("second flag dropped without a read");

         // Set first flag holds while no read clears it
         a_flag_a_hold: assert property (@(posedge sys_clk_i)
            disable iff (sys_rst_i)
            (flags_a[c][BIT_SIGNAL_LOSS] && !clr_a[c])
            |=> flags_a[c][BIT_SIGNAL_LOSS])
            else $error("first flag dropped without a read");

         // Clearing read with no new event empties the second flags
         a_clear_b_read: assert property (@(posedge sys_clk_i)
            disable iff (sys_rst_i)
            (clr_b[c] && (event_pulse_b_i[c] == 8'h00))
            |=> (flags_b[c] == 8'h00))
            else $error("second flags not cleared by read");

         // Loss goes up exactly after 71 idle cycles
         sequence s_loss_up;
            $rose(tx_loss[c]);
         endsequence
         a_txclk_loss: assert property (@(posedge sys_clk_i)
            disable iff (sys_rst_i)
            s_loss_up |-> ($past(tx_cnt[c]) == TX_LOSS_LIMIT))
            else $error("transmit clock loss at wrong count");

         // A synchronised toggle drops the loss one cycle later
         a_txclk_recover: assert property (@(posedge sys_clk_i)
            disable iff (sys_rst_i)
            (tx_sync2[c] != tx_prev[c]) |=> !tx_loss[c])
            else $error("transmit clock loss held after a toggle");
      end
   endgenerate

   // Read mux and interrupt request
   always_comb begin
      next_rd_data = rd_data_o;
      next_irq = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (((next_flags_a[i] & ~event_mask_a_i[i])
            | (next_flags_b[i] & ~event_mask_b_i[i])) != 8'h00) begin
            next_irq = 1'b1;
         end
      end
      if (rd_strobe_i) begin
         case (sel_ofs)
            OFS_LINE_STATUS_A: next_rd_data = status_a[sel_ch];
            OFS_LINE_STATUS_B: next_rd_data =
               {2'b00, remote_loop_state_i[sel_ch], 5'b00000};
            OFS_EVENT_FLAGS_A: next_rd_data = flags_a[sel_ch];
            OFS_EVENT_FLAGS_B: next_rd_data = flags_b[sel_ch];
            OFS_ERROR_COUNT_LOW:
               next_rd_data = error_count_i[sel_ch][7:0];
            OFS_ERROR_COUNT_HIGH:
               next_rd_data = error_count_i[sel_ch][15:8];
            default: next_rd_data = UNMAPPED_DATA;
         endcase
      end
   end

   // Port registers
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_data_o <= RESET_RD_DATA;
         irq_o <= 1'b0;
      end else begin
         rd_data_o <= next_rd_data;
         irq_o <= next_irq;
      end
   end

   // Any flag set in any channel, watched by the request check
   always_comb begin
      flag_seen = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         flag_seen = flag_seen | (|flags_a[i]) | (|flags_b[i]);
      end
   end

   // Counter low byte read returns the sampled low byte
   a_count_low: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (rd_strobe_i && sel_ofs == OFS_ERROR_COUNT_LOW)
      |=> (rd_data_o == $past(error_count_i[sel_ch][7:0])))
      else $error("counter low byte read mismatch");

   // Counter high byte read returns the sampled high byte
   a_count_high: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (rd_strobe_i && sel_ofs == OFS_ERROR_COUNT_HIGH)
      |=> (rd_data_o == $past(error_count_i[sel_ch][15:8])))
      else $error("counter high byte read mismatch");

   // First status readout carries the live loss state, bit 7 clear
   a_status_read: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (rd_strobe_i && sel_ofs == OFS_LINE_STATUS_A)
      |=> ((rd_data_o[BIT_SIGNAL_LOSS]
         == $past(signal_loss_state_i[sel_ch])) && !rd_data_o[7]))
      else $error("first status readout wrong");

   // Offsets outside the register set read as zero
   a_unmapped: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (rd_strobe_i && (sel_ofs < OFS_LINE_STATUS_A
         || sel_ofs > OFS_ERROR_COUNT_HIGH))
      |=> (rd_data_o == UNMAPPED_DATA))
      else $error("unmapped offset returned data");

   // Readout stands until the next read
   a_read_hold: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      !rd_strobe_i |=> $stable(rd_data_o))
      else $error("read data changed without a read");

   // Request is up whenever channel 0 holds an unmasked second flag, in the same cycle as the flag
   a_irq_level: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (((flags_b[0] & ~$past(event_mask_b_i[0])) != 8'h00) |-> irq_o))
      else $error("interrupt request missing for set flag");

   // Request is withdrawn once no flag is left set
   a_irq_source: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      irq_o |-> flag_seen)
      else $error("interrupt request without a set flag");

   // Remote loop readout places the state in bit 5 only
   a_remote_loop: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (rd_strobe_i && sel_ofs == OFS_LINE_STATUS_B)
      |=> (rd_data_o == {2'b00, $past(remote_loop_state_i[sel_ch]),
         5'b00000}))
      else $error("second status readout wrong");

endmodule

// *** test/test_line_status_interrupt_flags.sv ***
// Self-checking bench for the line status and event flag block.
// Assumes the package constants and a one-cycle registered read answer.
`timescale 1ns/10ps
module test_line_status_interrupt_flags;
   import line_status_pkg::*;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic rd_strobe_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] rd_data_o;
   logic irq_o;
   logic [NUM_CH-1:0] signal_loss_state_i = '0;
   logic [NUM_CH-1:0] remote_loop_state_i = '0;
   logic [NUM_CH-1:0] tx_clock_in_i = '0;
   logic [NUM_CH-1:0] tx_stop = '0;
   logic [NUM_CH-1:0] tx_loss = '0;
   logic [NUM_CH-1:0][7:0] line_alarm_i = '0;
   logic [NUM_CH-1:0][7:0] event_mask_a_i = '0;
   logic [NUM_CH-1:0][7:0] edge_select_a_i = '0;
   logic [NUM_CH-1:0][7:0] event_pulse_b_i = '0;
   logic [NUM_CH-1:0][7:0] event_mask_b_i = '0;
   logic [NUM_CH-1:0][15:0] error_count_i = '0;
   logic [7:0] flags_a [NUM_CH] = '{default: 8'h00};
   logic [7:0] flags_b [NUM_CH] = '{default: 8'h00};
   logic [7:0] hist [NUM_CH] = '{default: 8'h00};
   logic [4:0] ofs_q [$] = {5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19};
   int seed = 80;
   int bad_count = 0;
   int comparisons = 0;
   int ch;

   line_status_interrupt_flags dut (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .rd_strobe_i(rd_strobe_i), .addr_i(addr_i),
      .rd_data_o(rd_data_o), .irq_o(irq_o),
      .signal_loss_state_i(signal_loss_state_i),
      .line_alarm_i(line_alarm_i),
      .remote_loop_state_i(remote_loop_state_i),
      .tx_clock_in_i(tx_clock_in_i),
      .event_mask_a_i(event_mask_a_i), .edge_select_a_i(edge_select_a_i),
      .event_pulse_b_i(event_pulse_b_i), .event_mask_b_i(event_mask_b_i),
      .error_count_i(error_count_i)
   );

   // Master clock and free-running transmit clocks unless stopped
   always #2 sys_clk_i = ~sys_clk_i;
   always @(negedge sys_clk_i) begin
      tx_clock_in_i <= tx_clock_in_i ^ ~tx_stop;
   end

   // Expected first status register of one channel
   function automatic logic [7:0] stat_a(int c);
      return {1'b0, line_alarm_i[c][6:4], tx_loss[c], line_alarm_i[c][2:1],
         signal_loss_state_i[c]};
   endfunction

   // Expected request from unmasked flags
   function automatic logic exp_irq();
      for (int c = 0; c < NUM_CH; c++) begin
         if (((flags_a[c] & ~event_mask_a_i[c]) |
            (flags_b[c] & ~event_mask_b_i[c])) != 8'h00) return 1'b1;
      end
      return 1'b0;
   endfunction

   // Comparisons for bytes and single bits
   task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h got %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(string what, logic exp, logic got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %b got %b", what, exp, got);
      end
   endtask

   // Latch status edges into the model, let the design settle
   task automatic apply();
      logic [7:0] s;
      for (int c = 0; c < NUM_CH; c++) begin
         s = stat_a(c);
         flags_a[c] |= (s & ~hist[c])
            | ((s ^ hist[c]) & edge_select_a_i[c]);
         hist[c] = s;
      end
      repeat (6) @(negedge sys_clk_i);
      chk_bit("irq settled", exp_irq(), irq_o);
   endtask

   // One read, optionally with second-flag events on the same edge
   task automatic rd(int c, logic [4:0] o, logic [7:0] pulse);
      logic [7:0] e;
      @(negedge sys_clk_i);
      rd_strobe_i = 1'b1;
      addr_i = {3'(c), o};
      event_pulse_b_i[c] = pulse;
      case (o)
         OFS_LINE_STATUS_A: e = stat_a(c);
         OFS_LINE_STATUS_B: e = {2'b00, remote_loop_state_i[c], 5'h00};
         OFS_EVENT_FLAGS_A: e = flags_a[c];
         OFS_EVENT_FLAGS_B: e = flags_b[c];
         OFS_ERROR_COUNT_LOW: e = error_count_i[c][7:0];
         OFS_ERROR_COUNT_HIGH: e = error_count_i[c][15:8];
         default: e = UNMAPPED_DATA;
      endcase
      if (o == OFS_EVENT_FLAGS_A) flags_a[c] = 8'h00;
      if (o == OFS_EVENT_FLAGS_B) flags_b[c] = 8'h00;
      flags_b[c] |= pulse;
      @(negedge sys_clk_i);
      rd_strobe_i = 1'b0;
      event_pulse_b_i = '0;
      chk_byte("rd_data", e, rd_data_o);
      chk_bit("irq after read", exp_irq(), irq_o);
   endtask

   // Verdict and end of run
   task automatic close_out();
      if (bad_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Reset, reset values, random traffic, clock loss, final clear
   initial begin
      repeat (12) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
         foreach (ofs_q[i]) rd(c, ofs_q[i], 8'h00);
      end
      repeat (60) begin
         signal_loss_state_i = NUM_CH'($random(seed));
         remote_loop_state_i = NUM_CH'($random(seed));
         line_alarm_i = {$random(seed), $random(seed)};
         edge_select_a_i = {$random(seed), $random(seed)};
         event_mask_a_i = {$random(seed), $random(seed)}
            | {$random(seed), $random(seed)};
         event_mask_b_i = {$random(seed), $random(seed)}
            | {$random(seed), $random(seed)};
         error_count_i = {$random(seed), $random(seed),
            $random(seed), $random(seed)};
         apply();
         ch = $unsigned($random(seed)) % NUM_CH;
         foreach (ofs_q[i]) rd(ch, ofs_q[i], 8'($random(seed)));
      end
      tx_stop[3] = 1'b1;
      repeat (90) @(negedge sys_clk_i);
      tx_loss[3] = 1'b1;
      apply();
      rd(3, OFS_LINE_STATUS_A, 8'h00);
      rd(3, OFS_EVENT_FLAGS_A, 8'h00);
      tx_stop[3] = 1'b0;
      tx_loss[3] = 1'b0;
      apply();
      rd(3, OFS_LINE_STATUS_A, 8'h00);
      for (int c = 0; c < NUM_CH; c++) begin
         rd(c, OFS_EVENT_FLAGS_A, 8'h00);
         rd(c, OFS_EVENT_FLAGS_B, 8'h00);
      end
      chk_bit("irq idle", 1'b0, irq_o);
      close_out();
   end
endmodule
